// ===== sdb_pkg.sv
// Constants, opcodes and carrier types for the step/divide/branch unit.
// Assumes one machine cycle equals one mclk period.
package sdb_pkg;

  // Opcodes, full byte
  localparam logic [7:0] OP_INC_A     = 8'h04;
  localparam logic [7:0] OP_INC_DIR   = 8'h05;
  localparam logic [7:0] OP_DEC_A     = 8'h14;
  localparam logic [7:0] OP_DEC_DIR   = 8'h15;
  localparam logic [7:0] OP_DIV       = 8'h84;
  localparam logic [7:0] OP_INC_PTR   = 8'ha3;
  localparam logic [7:0] OP_LOOP_DIR  = 8'hd5;
  localparam logic [7:0] OP_BIT_ONE   = 8'h20;
  localparam logic [7:0] OP_BIT_CLR   = 8'h10;
  // Opcode families: upper bits compared, low bits select an operand
  localparam logic [4:0] OP_INC_WR    = 5'h01;
  localparam logic [4:0] OP_DEC_WR    = 5'h03;
  localparam logic [4:0] OP_LOOP_WR   = 5'h1b;
  localparam logic [6:0] OP_INC_IND   = 7'h03;
  localparam logic [6:0] OP_DEC_IND   = 7'h0b;

  // Special function byte addresses and the base of bit-addressable memory
  localparam logic [7:0] SFR_BASE     = 8'h80;
  localparam logic [7:0] SFR_PORT0    = 8'h80;
  localparam logic [7:0] SFR_PORT1    = 8'h90;
  localparam logic [7:0] SFR_PORT2    = 8'ha0;
  localparam logic [7:0] SFR_PORT3    = 8'hb0;
  localparam logic [7:0] SFR_PLOW     = 8'h82;
  localparam logic [7:0] SFR_PHIGH    = 8'h83;
  localparam logic [7:0] SFR_PSW      = 8'hd0;
  localparam logic [7:0] SFR_ACC      = 8'he0;
  localparam logic [7:0] SFR_B        = 8'hf0;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  // Status word fields
  localparam int PSW_CY      = 7;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OV      = 2;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  RST_LATCH = 8'hff;
  localparam logic [15:0] RST_PTR   = 16'h0000;

  // Instruction lengths and machine cycles
  localparam logic [1:0] LEN_1 = 2'd1;
  localparam logic [1:0] LEN_2 = 2'd2;
  localparam logic [1:0] LEN_3 = 2'd3;
  localparam logic [2:0] CYC_1 = 3'd1;
  localparam logic [2:0] CYC_2 = 3'd2;
  localparam logic [2:0] CYC_4 = 3'd4;

  typedef enum {
    K_DEC, K_INC, K_INCPTR, K_DIV, K_LOOP, K_BITONE, K_BITCLR, K_BAD
  } sdb_kind_t;

  typedef enum { SP_ACC, SP_DIR, SP_IND, SP_BIT, SP_NONE } sdb_space_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  arg1;
    logic [7:0]  arg2;
    logic [15:0] pc;
  } sdb_instr_t;

  typedef struct packed {
    logic [15:0] next_pc;
    logic        taken;
    logic        illegal;
  } sdb_result_t;

  typedef struct packed {
    logic       we;
    logic       ind;
    logic [7:0] addr;
    logic [7:0] data;
  } sdb_load_t;

endpackage

// ===== sdb_exec.sv
// Execution unit for decrement, increment, pointer increment, divide,
// count-down loop and bit-test branches of an 8-bit core.
// Assumes the core issues one instruction at a time while ready is high.
// Port pins arrive asynchronously and are synchronised here.

////////////////////////////////////////////////////////////////////////
// How it works
// - Decrement subtracts one modulo 256 and leaves all flags alone.
// - Decrement works on accumulator, working register, direct or indirect byte in one cycle, direct form two bytes.
// - Decrement, increment and loop on a port read the output latch, not the pins.
// - Divide puts A div B in the accumulator and A mod B in B, taking four cycles.
// - Divide with a nonzero divisor clears carry and the signed range flag.
// - Divide by zero sets the signed range flag and clears carry.
// - The loop decrements modulo 256 with no flag change and branches only on a nonzero result.
// - The loop target is the next instruction address plus the signed last byte.
// - The loop takes a working register in two bytes or a direct byte in three, two cycles each.
// - Increment adds one modulo 256 and leaves all flags alone.
// - Increment works on accumulator, working register, direct or indirect byte in one cycle, direct form two bytes.
// - Pointer increment adds one modulo 65536 over both bytes, no flags, two cycles.
// - Bit-one branch jumps on a one and changes neither the bit nor any flag.
// - Both bit branches target next address plus signed third byte, three bytes, two cycles.
// - Bit-one-then-clear jumps on a one and always leaves the bit cleared.
// - Bit-one-then-clear on a port bit tests the output latch.
module sdb_exec
  import sdb_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        instr_valid,
  input  wire sdb_instr_t  instr,
  output logic             ready,
  output logic             done_q,
  output sdb_result_t      result_q,
  input  wire sdb_load_t   load,
  input  wire logic        peek_ind,
  input  wire logic [7:0]  peek_addr,
  output logic [7:0]       peek_data_q,
  input  wire logic [31:0] port_pins,
  output logic [31:0]      port_latch_q,
  output logic [7:0]       acc_q,
  output logic [7:0]       b_q,
  output logic [7:0]       psw_q,
  output logic [15:0]      pointer_sixteen_q
);

  typedef struct packed {
    sdb_kind_t  kind;
    sdb_space_t space;
    logic [1:0] len;
    logic [2:0] cyc;
    logic [7:0] addr;
    logic [7:0] rel;
  } sdb_dec_t;

  typedef enum { ST_IDLE, ST_EXEC } sdb_state_t;

  logic [7:0]  ram [256];
  logic [31:0] pins_meta_q;
  logic [31:0] pins_q;
  sdb_state_t  state_q;
  sdb_dec_t    dec_q;
  logic [2:0]  cnt_q;
  logic [7:0]  val_q;
  logic [7:0]  ea_q;
  logic [15:0] pc_q;
  logic [1:0]  bank;
  sdb_dec_t    dec_d;
  logic [7:0]  ea_d;
  logic [7:0]  val_d;
  logic        commit;
  logic        w_en;
  logic        w_ram;
  logic [7:0]  w_addr;
  logic [7:0]  w_data;
  logic [7:0]  res_byte;
  logic        bit_val;
  logic [15:0] fall_pc;
  logic [15:0] jump_pc;
  logic        take;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic sdb_dec_t decode(input logic [7:0] op,
                                      input logic [7:0] a1,
                                      input logic [7:0] a2,
                                      input logic [1:0] bk);
    sdb_dec_t d;
    d = '{K_BAD, SP_NONE, LEN_1, CYC_1, 8'h00, 8'h00};
    if (op == OP_DEC_A || op == OP_INC_A) begin
      d.kind  = (op == OP_DEC_A) ? K_DEC : K_INC;
      d.space = SP_ACC;
    end else if (op == OP_DEC_DIR || op == OP_INC_DIR) begin
      d.kind  = (op == OP_DEC_DIR) ? K_DEC : K_INC;
      d.space = SP_DIR;
      d.len   = LEN_2;
      d.addr  = a1;
    end else if (op[7:3] == OP_DEC_WR || op[7:3] == OP_INC_WR) begin
      d.kind  = (op[7:3] == OP_DEC_WR) ? K_DEC : K_INC;
      d.space = SP_DIR;
      d.addr  = {3'h0, bk, op[2:0]};
    end else if (op[7:1] == OP_DEC_IND || op[7:1] == OP_INC_IND) begin
      d.kind  = (op[7:1] == OP_DEC_IND) ? K_DEC : K_INC;
      d.space = SP_IND;
      d.addr  = {3'h0, bk, 2'h0, op[0]};
    end else if (op == OP_DIV) begin
      d.kind  = K_DIV;
      d.cyc   = CYC_4;
    end else if (op == OP_INC_PTR) begin
      d.kind  = K_INCPTR;
      d.cyc   = CYC_2;
    end else if (op[7:3] == OP_LOOP_WR) begin
      d = '{K_LOOP, SP_DIR, LEN_2, CYC_2, {3'h0, bk, op[2:0]}, a1};
    end else if (op == OP_LOOP_DIR) begin
      d = '{K_LOOP, SP_DIR, LEN_3, CYC_2, a1, a2};
    end else if (op == OP_BIT_ONE || op == OP_BIT_CLR) begin
      d.kind  = (op == OP_BIT_ONE) ? K_BITONE : K_BITCLR;
      d.space = SP_BIT;
      d.len   = LEN_3;
      d.cyc   = CYC_2;
      d.addr  = a1;
      d.rel   = a2;
    end
    return d;
  endfunction

  // Byte that holds an addressable bit
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    return ba[7] ? {ba[7:3], 3'h0} : (BIT_RAM_BASE + {4'h0, ba[6:3]});
  endfunction

  // Special register read; a modifying access sees the port latch
  function automatic logic [7:0] sfr_rd(input logic [7:0]  a,
                                        input logic        rmw,
                                        input logic [31:0] lat,
                                        input logic [31:0] pin,
                                        input logic [7:0]  ac,
                                        input logic [7:0]  bb,
                                        input logic [7:0]  ps,
                                        input logic [15:0] dp);
    logic [31:0] src;
    src = rmw ? lat : pin;
    case (a)
      SFR_PORT0: sfr_rd = src[7:0];
      SFR_PORT1: sfr_rd = src[15:8];
      SFR_PORT2: sfr_rd = src[23:16];
      SFR_PORT3: sfr_rd = src[31:24];
      SFR_PLOW:  sfr_rd = dp[7:0];
      SFR_PHIGH: sfr_rd = dp[15:8];
      SFR_PSW:   sfr_rd = ps;
      SFR_ACC:   sfr_rd = ac;
      SFR_B:     sfr_rd = bb;
      default:   sfr_rd = 8'h00;
    endcase
  endfunction

  // Sign-extended relative branch
  function automatic logic [15:0] rel_add(input logic [15:0] base,
                                          input logic [7:0]  rel);
    return base + {{8{rel[7]}}, rel};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Operand fetch at issue
  assign bank  = psw_q[PSW_BANK_HI:PSW_BANK_LO];
  assign ready = (state_q == ST_IDLE);

  always_comb begin
    logic [7:0] ba;
    ba    = 8'h00;
    dec_d = decode(instr.opcode, instr.arg1, instr.arg2, bank);
    ea_d  = dec_d.addr;
    val_d = 8'h00;
    case (dec_d.space)
      SP_ACC: begin
        ea_d  = SFR_ACC;
        val_d = acc_q;
      end
      SP_DIR: begin
        if (ea_d >= SFR_BASE) begin
          val_d = sfr_rd(ea_d, 1'b1, port_latch_q, pins_q, acc_q, b_q,
                         psw_q, pointer_sixteen_q);
        end else begin
          val_d = ram[ea_d];
        end
      end
      SP_IND: begin
        ea_d  = ram[dec_d.addr];
        val_d = ram[ea_d];
      end
      SP_BIT: begin
        ba   = dec_d.addr;
        ea_d = bit_byte(ba);
        if (ba[7]) begin
          val_d = sfr_rd(ea_d, dec_d.kind == K_BITCLR, port_latch_q,
                         pins_q, acc_q, b_q, psw_q,
                         pointer_sixteen_q);
        end else begin
          val_d = ram[ea_d];
        end
      end
      default: val_d = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencing: the unit is busy for the instruction's machine cycles
  assign commit = (state_q == ST_EXEC) && (cnt_q == 3'd1);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            state_q <= ST_EXEC;
            cnt_q   <= dec_d.cyc;
          end
        end
        ST_EXEC: begin
          cnt_q <= cnt_q - 3'd1;
          if (cnt_q == 3'd1) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dec_q <= '{K_BAD, SP_NONE, LEN_1, CYC_1, 8'h00, 8'h00};
      val_q <= RST_BYTE;
      ea_q  <= RST_BYTE;
      pc_q  <= 16'h0000;
    end else if (ready && instr_valid) begin
      dec_q <= dec_d;
      val_q <= val_d;
      ea_q  <= ea_d;
      pc_q  <= instr.pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result and write-back
  assign bit_val = val_q[dec_q.addr[2:0]];
  assign fall_pc = pc_q + {14'h0, dec_q.len};
  assign jump_pc = rel_add(fall_pc, dec_q.rel);

  always_comb begin
    res_byte = val_q;
    take     = 1'b0;
    case (dec_q.kind)
      K_DEC:    res_byte = val_q - 8'h01;
      K_INC:    res_byte = val_q + 8'h01;
      K_LOOP: begin
        res_byte = val_q - 8'h01;
        take     = (res_byte != 8'h00);
      end
      K_BITONE: take = bit_val;
      K_BITCLR: begin
        take = bit_val;
        res_byte = val_q & ~(8'h01 << dec_q.addr[2:0]);
      end
      default: res_byte = val_q;
    endcase
  end

  // Instruction write wins over the side-load port in the same cycle
  always_comb begin
    w_en   = load.we;
    w_ram  = load.ind || (load.addr < SFR_BASE);
    w_addr = load.addr;
    w_data = load.data;
    if (commit && (dec_q.kind == K_DEC || dec_q.kind == K_INC ||
                   dec_q.kind == K_LOOP || dec_q.kind == K_BITCLR)) begin
      w_en   = 1'b1;
      w_ram  = (dec_q.space == SP_IND) || (ea_q < SFR_BASE);
      w_addr = ea_q;
      w_data = res_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (w_en && w_ram) begin
      ram[w_addr] <= w_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= RST_BYTE;
    end else if (commit && dec_q.kind == K_DIV) begin
      if (b_q != 8'h00) begin
        acc_q <= acc_q / b_q;
      end
    end else if (w_en && !w_ram && w_addr == SFR_ACC) begin
      acc_q <= w_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      b_q <= RST_BYTE;
    end else if (commit && dec_q.kind == K_DIV) begin
      if (b_q != 8'h00) begin
        b_q <= acc_q % b_q;
      end
    end else if (w_en && !w_ram && w_addr == SFR_B) begin
      b_q <= w_data;
    end
  end

  // Only divide sets flags itself; other kinds change them only when they write the status byte as their operand
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      psw_q <= RST_BYTE;
    end else if (commit && dec_q.kind == K_DIV) begin
      psw_q[PSW_CY] <= 1'b0;
      psw_q[PSW_OV] <= (b_q == 8'h00);
    end else if (w_en && !w_ram && w_addr == SFR_PSW) begin
      psw_q <= w_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pointer_sixteen_q <= RST_PTR;
    end else if (commit && dec_q.kind == K_INCPTR) begin
      pointer_sixteen_q <= pointer_sixteen_q + 16'h0001;
    end else if (w_en && !w_ram && w_addr == SFR_PLOW) begin
      pointer_sixteen_q[7:0] <= w_data;
    end else if (w_en && !w_ram && w_addr == SFR_PHIGH) begin
      pointer_sixteen_q[15:8] <= w_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_latch_q <= {4{RST_LATCH}};
    end else if (w_en && !w_ram) begin
      case (w_addr)
        SFR_PORT0: port_latch_q[7:0]   <= w_data;
        SFR_PORT1: port_latch_q[15:8]  <= w_data;
        SFR_PORT2: port_latch_q[23:16] <= w_data;
        SFR_PORT3: port_latch_q[31:24] <= w_data;
        default:   port_latch_q        <= port_latch_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins and observation
  // Two flops before any use; a plain bit test sees pins two edges late
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pins_meta_q <= 32'h0000_0000;
      pins_q      <= 32'h0000_0000;
    end else begin
      pins_meta_q <= port_pins;
      pins_q      <= pins_meta_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_q   <= 1'b0;
      result_q <= '0;
    end else begin
      done_q <= commit;
      if (commit) begin
        result_q.taken   <= take;
        result_q.next_pc <= take ? jump_pc : fall_pc;
        result_q.illegal <= (dec_q.kind == K_BAD);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peek_data_q <= RST_BYTE;
    end else if (peek_ind || peek_addr < SFR_BASE) begin
      peek_data_q <= ram[peek_addr];
    end else begin
      peek_data_q <= sfr_rd(peek_addr, 1'b1, port_latch_q, pins_q, acc_q,
                            b_q, psw_q, pointer_sixteen_q);
    end
  end

endmodule

// ===== sdb_exec_props.sv
// Checker for sdb_exec: done timing, results and flags.
// Assumes no side load write lands while an instruction runs.
module sdb_exec_props
  import sdb_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        instr_valid,
  input wire sdb_instr_t  instr,
  input wire logic        ready,
  input wire logic        done_q,
  input wire sdb_result_t result_q,
  input wire logic [7:0]  acc_q,
  input wire logic [7:0]  b_q,
  input wire logic [7:0]  psw_q,
  input wire logic [15:0] pointer_sixteen_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
////////////////////////////////////////////////////////////
  logic [7:0] op;
  logic       take, two, dv, bb, oa, bitv;
  assign op   = instr.opcode;
  assign take = instr_valid && ready;
  assign dv   = op == OP_DIV;
  assign bb   = op == OP_BIT_ONE || op == OP_BIT_CLR;
  assign two  = op == OP_INC_PTR || op == OP_LOOP_DIR || bb
              || op[7:3] == OP_LOOP_WR;
  // Bit branch on an accumulator bit, the only bit seen here
  assign oa   = bb && instr.arg1[7:3] == 5'h1c;
  assign bitv = acc_q[instr.arg1[2:0]];
////////////////////////////////////////////////////////////
  // Done rises on the edge that commits, so it is seen one edge later
  sequence s_one;  ##1 !done_q [*1] ##1 done_q ##1 !done_q; endsequence
  sequence s_two;  ##1 !done_q [*2] ##1 done_q ##1 !done_q; endsequence
  sequence s_four; ##1 !done_q [*4] ##1 done_q ##1 !done_q; endsequence

  a_short_done: assert property (take && !two && !dv |-> s_one)
    else $error("one cycle op done pulse misplaced");
  a_busy_ready: assert property (take && !two && !dv |=>
    !ready ##1 ready)
    else $error("ready wrong around a one cycle op");
  a_two_done: assert property (take && two |-> s_two)
    else $error("two cycle op done pulse misplaced");
  a_div_done: assert property (take && dv |-> s_four)
    else $error("divide done pulse misplaced");
  a_acc_step: assert property (take && (op | 8'h10) == OP_DEC_A
    |-> ##2 psw_q == $past(psw_q, 2) && acc_q == ($past(op, 2) == OP_INC_A
    ? $past(acc_q, 2) + 8'h01 : $past(acc_q, 2) - 8'h01))
    else $error("accumulator step wrong");
  a_div_flags: assert property (take && dv |-> ##5 !psw_q[PSW_CY]
    && psw_q[PSW_OV] == ($past(b_q, 5) == 8'h00))
    else $error("divide flags wrong");
  a_div_value: assert property (take && dv && b_q != 8'h00 |-> ##5
    acc_q == $past(acc_q, 5) / $past(b_q, 5)
    && b_q == $past(acc_q, 5) % $past(b_q, 5))
    else $error("divide result wrong");
  a_ptr_step: assert property (take && op == OP_INC_PTR |-> ##3
    pointer_sixteen_q == $past(pointer_sixteen_q, 3) + 16'h0001
    && psw_q == $past(psw_q, 3))
    else $error("pointer step wrong");
  a_bit_target: assert property (take && bb |-> ##4
    result_q.next_pc == $past(instr.pc, 4) + 16'h0003 + (result_q.taken
    ? {{8{$past(instr.arg2[7], 4)}}, $past(instr.arg2, 4)} : 16'h0000))
    else $error("bit branch target wrong");
  a_bit_keep: assert property (take && oa && op == OP_BIT_ONE
    |-> ##3 acc_q == $past(acc_q, 3) ##1 result_q.taken == $past(bitv, 4))
    else $error("bit test altered bit or branched wrongly");
  a_bit_clear: assert property (take && oa && op == OP_BIT_CLR |-> ##3
    acc_q == ($past(acc_q, 3) & ~(8'h01 << $past(instr.arg1[2:0], 3)))
    ##1 result_q.taken == $past(bitv, 4))
    else $error("bit clear branch wrong");
endmodule

bind sdb_exec sdb_exec_props u_props (.mclk, .resetn, .instr_valid, .instr,
  .ready, .done_q, .result_q, .acc_q, .b_q, .psw_q, .pointer_sixteen_q);

// ===== sdb_exec_tb_top.sv
// Self-checking bench for sdb_exec with random and corner operands.
// Assumes the checker is bound to the design by its own file.
module sdb_exec_tb_top
  import sdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Opcode that the unit does not decode
  localparam logic [7:0] OP_NONE = 8'h00;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        instr_valid = 1'b0;
  sdb_instr_t  instr = '0;
  sdb_load_t   load = '0;
  logic        peek_ind = 1'b0;
  logic [7:0]  peek_addr = 8'h00;
  logic        ready, done_q;
  sdb_result_t result_q;
  logic [7:0]  peek_data_q, acc_q, b_q, psw_q;
  logic [31:0] port_pins, port_latch_q;
  logic [15:0] pointer_sixteen_q;
  int          fail_count = 0;
  int          tests_run = 0;
  // Pins always oppose the latch, so reading the wrong source shows
  assign port_pins = ~port_latch_q;
  always #10 mclk = ~mclk;
  sdb_exec uut (.mclk, .resetn, .instr_valid, .instr, .ready, .done_q,
    .result_q, .load, .peek_ind, .peek_addr, .peek_data_q, .port_pins,
    .port_latch_q, .acc_q, .b_q, .psw_q, .pointer_sixteen_q);
////////////////////////////////////////////////////////////
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] stp(input logic [7:0] v, input logic up);
    return up ? v + 8'h01 : v - 8'h01;
  endfunction
  task automatic ld(input logic i, input logic [7:0] a, d);
    // Strobe stays up until the next issue, so back to back loads never
    // drop and raise it in one step
    load = '{1'b1, i, a, d};
    @(posedge mclk);
    #1;
  endtask
  task automatic pk(input logic i, input logic [7:0] a,
                    output logic [7:0] d);
    peek_ind = i;
    peek_addr = a;
    @(posedge mclk);
    #1 d = peek_data_q;
  endtask
  // Issue one instruction, count edges to done, check branch result
  task automatic go(input logic [7:0] op, a1, a2, input int n, len,
                    input logic tk);
    logic [7:0]  rel;
    logic [15:0] e;
    int          c;
    rel = (len == 2) ? a1 : a2;
    load.we = 1'b0;
    instr = '{op, a1, a2, 16'($urandom)};
    instr_valid = 1'b1;
    @(posedge mclk);
    #1 instr_valid = 1'b0;
    c = 0;
    while (done_q !== 1'b1) begin
      if (c == 9) begin
        fail_count++;
        test_done;
      end
      @(posedge mclk);
      #1 c++;
    end
    e = instr.pc + 16'(len) + (tk ? {{8{rel[7]}}, rel} : 16'h0000);
    chk("cycles", 16'(n), 16'(c));
    chk("illegal", {15'h0, op == OP_NONE}, {15'h0, result_q.illegal});
    chk("next_pc", e, result_q.next_pc);
    chk("taken", {15'h0, tk}, {15'h0, result_q.taken});
  endtask
////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0]  v, a, d, x;
    logic [1:0]  b;
    logic [2:0]  k;
    logic        u;
    void'($urandom(32'hd782));
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 96; i++) begin
      r = $urandom;
      v = r[7:0];
      if (i < 24) v = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'hff : 8'h01;
      u = r[24];
      b = r[20:19];
      k = r[18:16];
      x = 8'($urandom);
      case (i % 8)
        0: begin
          ld(1'b0, SFR_PSW, r[15:8]);
          ld(1'b0, SFR_ACC, v);
          go(u ? OP_INC_A : OP_DEC_A, 0, 0, 1, 1, 0);
          chk("acc", stp(v, u), acc_q);
          chk("psw", r[15:8], psw_q);
          go(OP_NONE, 0, 0, 1, 1, 0);
          chk("acc_none", stp(v, u), acc_q);
        end
        1: begin
          ld(1'b0, SFR_PSW, {3'b0, b, 3'b0});
          ld(1'b1, {3'b0, b, k}, v);
          go(u ? {OP_INC_WR, k} : {OP_DEC_WR, k}, 0, 0, 1, 1, 0);
          pk(1'b1, {3'b0, b, k}, d);
          chk("wreg", stp(v, u), d);
        end
        2: begin
          // Target above 7fh: indirect must still reach plain memory
          a = {1'b1, r[14:8]};
          ld(1'b0, SFR_PSW, {3'b0, b, 3'b0});
          ld(1'b1, {3'b0, b, 2'b0, r[15]}, a);
          ld(1'b1, a, v);
          x = u ? {OP_INC_IND, r[15]} : {OP_DEC_IND, r[15]};
          go(x, 0, 0, 1, 1, 0);
          pk(1'b1, a, d);
          chk("ind", stp(v, u), d);
        end
        3: begin
          a = {2'b10, r[9:8], 4'h0};
          ld(1'b0, a, v);
          go(u ? OP_INC_DIR : OP_DEC_DIR, a, 0, 1, 2, 0);
          chk("latch", stp(v, u), port_latch_q[{r[9:8], 3'b0} +: 8]);
        end
        4: begin
          x = (i < 24 && i % 3 == 0) ? 8'h00 : r[15:8];
          ld(1'b0, SFR_PSW, 8'h84);
          ld(1'b0, SFR_ACC, v);
          ld(1'b0, SFR_B, x);
          go(OP_DIV, 0, 0, 4, 1, 0);
          chk("psw", (x == 8'h00) ? 8'h04 : 8'h00, psw_q);
          if (x != 8'h00) begin
            chk("quot", v / x, acc_q);
            chk("rem", v % x, b_q);
          end
        end
        5: begin
          x = (i < 24) ? 8'hff : r[15:8];
          ld(1'b0, SFR_PLOW, v);
          ld(1'b0, SFR_PHIGH, x);
          go(OP_INC_PTR, 0, 0, 2, 1, 0);
          chk("ptr", {x, v} + 16'h0001, pointer_sixteen_q);
        end
        6: begin
          if (u) begin
            a = r[25] ? SFR_PORT1 : {1'b0, r[14:8]};
            ld(1'b0, a, v);
            go(OP_LOOP_DIR, a, x, 2, 3, stp(v, 0) != 0);
            pk(1'b0, a, d);
          end else begin
            ld(1'b0, SFR_PSW, {3'b0, b, 3'b0});
            ld(1'b1, {3'b0, b, k}, v);
            go({OP_LOOP_WR, k}, x, 0, 2, 2, stp(v, 0) != 0);
            pk(1'b1, {3'b0, b, k}, d);
          end
          chk("loop", stp(v, 0), d);
        end
        default: begin
          // Plain test on a port sees synced pins; allow two sync edges
          a = r[25] ? SFR_PORT2 : SFR_ACC;
          ld(1'b0, a, v);
          repeat (2) @(posedge mclk);
          #1;
          go(u ? OP_BIT_CLR : OP_BIT_ONE, a | k, x, 2, 3,
             (r[25] && !u) ? ~v[k] : v[k]);
          pk(1'b0, a, d);
          chk("bit", u ? v & ~(8'h01 << k) : v, d);
        end
      endcase
    end
    test_done;
  end
endmodule
